//--- supply_comp_map.vh
`ifndef SUPPLY_COMP_MAP_VH
`define SUPPLY_COMP_MAP_VH
// ==========================================================
// register offsets
`define SC_ADDR_CONTROL 8'h22
`define SC_ADDR_TIMING 8'h23
`define SC_ADDR_STATUS 8'h89
`define SC_ADDR_IRQ_STATUS 8'h90
`define SC_ADDR_IRQ_MASK 8'h91
`define SC_ADDR_LOCKOUT 8'h92
// ==========================================================
// reset values
`define SC_CONTROL_RESET 8'h08
`define SC_TIMING_RESET 6'h04
`define SC_LOCKOUT_RESET 1'b1
// ==========================================================
// control field positions
`define SC_ATTEN_BIT 7
`define SC_BOOST_BIT 6
`define SC_JUMP_EN_BIT 5
`define SC_TARGET_MSB 4
`define SC_TARGET_LSB 0
// timing field positions
`define SC_AVG_MSB 5
`define SC_AVG_LSB 3
`define SC_PERIOD_MSB 2
`define SC_PERIOD_LSB 0
// status field positions
`define SC_JUMP_FLAG_BIT 7
// interrupt bit positions
`define SC_IRQ_JUMP 0
`define SC_IRQ_UNDERVOLT 1
`define SC_IRQ_UPDATE 2
// ==========================================================
// timing and correction limits
`define SC_CLK_PERIOD_NS 20
`define SC_BASE_PERIOD_NS 62500
`define SC_UV_HOLD_MS 200
`define SC_JUMP_LIMIT 5'h04
`define SC_CORR_MIN 6'h20
`define SC_CORR_MAX 6'h1F
`endif

//--- supply_compensated_gain_control.v
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "supply_comp_map.vh"

module supply_compensated_gain_control
#(
  // cycles per 0.0625ms sense base period
  parameter BASE_PERIOD_CYCLES =
    `SC_BASE_PERIOD_NS / `SC_CLK_PERIOD_NS,
  // cycles of continuous zero code before undervolt
  parameter UV_HOLD_CYCLES =
    `SC_UV_HOLD_MS * 1000000 / `SC_CLK_PERIOD_NS
)
(
  input wire clock,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [4:0] power_stage_supply,
  input wire signed [15:0] sample_in,
  input wire sample_in_valid,
  output reg signed [15:0] sample_out,
  output reg sample_out_valid,
  output wire bridge_output_enable,
  output wire irq
);

  // ========================================================
  // helpers
  // 2^(c/32) in Q2.14, quadratic fit of the mantissa;
  // accuracy near 1% is enough for a supply trim
  function [16:0] corr_to_gain;
    input [5:0] c;
    reg [4:0] m;
    reg [31:0] mant;
    begin
      m = c[4:0];
      mant = 32'h0000_4000 + ((m * 32'h0000_2A09) >> 5)
        + ((m * m * 32'h0000_15F7) >> 10);
      // negative codes sit one octave lower
      corr_to_gain = c[5] ? mant[17:1] : mant[16:0];
    end
  endfunction

  // saturate a 7-bit signed value to 6 bits
  function [5:0] sat6;
    input [6:0] v;
    begin
      if (!v[6] && v[5])
        sat6 = `SC_CORR_MAX;
      else if (v[6] && !v[5])
        sat6 = `SC_CORR_MIN;
      else
        sat6 = v[5:0];
    end
  endfunction

  // ========================================================
  // registers
  reg [7:0] control; // enables and target
  reg [5:0] timing; // average and period selects
  reg lockout_enable; // undervolt lockout enable
  reg [2:0] irq_status; // sticky events
  reg [2:0] irq_mask; // event gates
  reg signed [5:0] correction; // applied correction
  reg jump_active; // jump ramp in progress
  reg undervolt; // zero code held long enough

  wire [4:0] target = control[`SC_TARGET_MSB:`SC_TARGET_LSB];
  wire [2:0] avg_sel = timing[`SC_AVG_MSB:`SC_AVG_LSB];
  wire [2:0] per_sel = timing[`SC_PERIOD_MSB:`SC_PERIOD_LSB];

  // ========================================================
  // register writes
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      control <= `SC_CONTROL_RESET;
      timing <= `SC_TIMING_RESET;
      lockout_enable <= `SC_LOCKOUT_RESET;
      irq_mask <= 3'h0;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `SC_ADDR_CONTROL: control <= reg_wdata;
        `SC_ADDR_TIMING: timing <= reg_wdata[5:0];
        `SC_ADDR_LOCKOUT: lockout_enable <= reg_wdata[0];
        `SC_ADDR_IRQ_MASK: irq_mask <= reg_wdata[2:0];
        default: ; // read-only, unmapped, or irq status (its write-one clear is handled below)
      endcase
    end
  end

  // ========================================================
  // read data, one cycle after the strobe
  always @(posedge clock)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `SC_ADDR_CONTROL: reg_rdata <= control;
        `SC_ADDR_TIMING: reg_rdata <= {2'b00, timing};
        // jump flag and live correction
        `SC_ADDR_STATUS:
          reg_rdata <= {jump_active, 1'b0, correction};
        `SC_ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
        `SC_ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
        `SC_ADDR_LOCKOUT:
          reg_rdata <= {6'h00, undervolt, lockout_enable};
        default: reg_rdata <= 8'h00; // unmapped reads zero
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ========================================================
  // sense period timer
  reg [22:0] period_count; // cycles into this period
  wire [22:0] period_len;
  wire sense_tick;

  // base period doubled per select code
  assign period_len = BASE_PERIOD_CYCLES[22:0] << per_sel;
  assign sense_tick = (period_count >= period_len - 23'h00_0001);

  always @(posedge clock)
  begin
    if (sys_rst || sense_tick)
      period_count <= 23'h00_0000;
    else
      period_count <= period_count + 23'h00_0001;
  end

  // ========================================================
  // averaging window
  reg [11:0] sum; // up to 128 codes of 31
  reg [7:0] sample_count; // samples taken in window
  reg [4:0] last_code; // previous sense sample
  reg have_last; // last_code is meaningful
  wire [7:0] window_len = 8'h01 << avg_sel;
  wire window_done = sense_tick &&
    (sample_count >= window_len - 8'h01);
  wire [11:0] next_sum = sum + {7'h00, power_stage_supply};
  wire [11:0] avg_wide = next_sum >> avg_sel;
  wire [4:0] average = avg_wide[4:0];

  // one sample per period
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      sum <= 12'h000;
      sample_count <= 8'h00;
      last_code <= 5'h00;
      have_last <= 1'b0;
    end
    else if (sense_tick)
    begin
      last_code <= power_stage_supply;
      have_last <= 1'b1;
      if (window_done)
      begin
        sum <= 12'h000;
        sample_count <= 8'h00;
      end
      else
      begin
        sum <= next_sum;
        sample_count <= sample_count + 8'h01;
      end
    end
  end

  // ========================================================
  // correction target from average
  // positive diff: supply below target, gain needed
  wire [6:0] diff = {2'b00, target} - {2'b00, average};
  reg [5:0] wanted; // clamped desired correction

  always @*
  begin
    wanted = sat6(diff);
    // disabled direction falls back to zero, the most
    // correction still allowed on that side
    if (!wanted[5] && !control[`SC_BOOST_BIT])
      wanted = 6'h00;
    else if (wanted[5] && !control[`SC_ATTEN_BIT])
      wanted = 6'h00;
  end

  // positive jump bigger than the limit
  wire jump_seen = sense_tick && have_last &&
    control[`SC_JUMP_EN_BIT] &&
    (power_stage_supply > last_code) &&
    (power_stage_supply - last_code > `SC_JUMP_LIMIT);

  reg [5:0] held_target; // last computed correction

  // ========================================================
  // correction state
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      correction <= 6'h00;
      held_target <= 6'h00;
      jump_active <= 1'b0;
    end
    else if (jump_seen)
    begin
      // drop to the floor at once
      correction <= `SC_CORR_MIN;
      jump_active <= 1'b1;
    end
    else if (sense_tick)
    begin
      if (window_done)
        held_target <= wanted;
      if (jump_active)
      begin
        // climb one step per period back to target
        if ($signed(correction) < $signed(held_target))
          correction <= correction + 6'h01;
        else
          jump_active <= 1'b0;
      end
      else if (window_done)
        correction <= wanted;
    end
  end

  // ========================================================
  // undervolt detect: zero code must hold without a break
  // so supply noise at the floor cannot shut us down
  reg [23:0] zero_count; // cycles of continuous zero code

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      zero_count <= 24'h00_0000;
      undervolt <= 1'b0;
    end
    else if (power_stage_supply != 5'h00)
    begin
      zero_count <= 24'h00_0000;
      undervolt <= 1'b0;
    end
    else if (zero_count >= UV_HOLD_CYCLES[23:0] - 24'h00_0001)
      undervolt <= 1'b1;
    else
      zero_count <= zero_count + 24'h00_0001;
  end

  // output bridge off while locked out
  assign bridge_output_enable = !(lockout_enable && undervolt);

  // ========================================================
  // audio path
  wire [16:0] gain = corr_to_gain(correction);
  wire signed [33:0] product =
    $signed(sample_in) * $signed({1'b0, gain});
  wire signed [19:0] scaled = product[33:14];

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      sample_out <= 16'h0000;
      sample_out_valid <= 1'b0;
    end
    else
    begin
      sample_out_valid <= sample_in_valid;
      if (!bridge_output_enable)
        sample_out <= 16'h0000;
      else if (!sample_in_valid)
        sample_out <= sample_out;
      else if (scaled > 20'sh0_7FFF)
        sample_out <= 16'h7FFF; // clip positive
      else if (scaled < -20'sh0_8000)
        sample_out <= 16'h8000; // clip negative
      else
        sample_out <= scaled[15:0];
    end
  end

  // ========================================================
  // interrupts: set wins over a write-one clear
  reg undervolt_d; // edge detect of undervolt
  wire [2:0] events = {window_done, undervolt && !undervolt_d,
    jump_seen};
  wire [2:0] clear_bits = (reg_write &&
    reg_addr == `SC_ADDR_IRQ_STATUS) ? reg_wdata[2:0] : 3'h0;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      irq_status <= 3'h0;
      undervolt_d <= 1'b0;
    end
    else
    begin
      undervolt_d <= undervolt;
      irq_status <= (irq_status & ~clear_bits) | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // supply_compensated_gain_control
`default_nettype wire

//--- supply_sense_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// supply sense converter: the code follows the level set by the bench,
// registered like a real converter output, so a change lands one cycle late
module supply_sense_model
(
  input wire logic clock,
  input wire logic [4:0] level,
  output logic [4:0] code
);
  // one conversion per clock, no filtering: noise is the bench's job
  always_ff @(posedge clock)
  begin
    code <= level;
  end
endmodule // supply_sense_model
`default_nettype wire

//--- supply_comp_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// port checker
module supply_comp_checker #(parameter UV_HOLD_CYCLES = 50)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] power_stage_supply,
  input wire logic sample_in_valid,
  input wire logic signed [15:0] sample_out,
  input wire logic sample_out_valid,
  input wire logic bridge_output_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // run length of zero codes, to judge the lockout delay
  logic [31:0] zero_run;
  always_ff @(posedge clock)
  begin
    if (sys_rst || power_stage_supply != 5'h00)
      zero_run <= '0;
    else
      zero_run <= zero_run + 1;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_CONTROL_BACK: assert property (reg_write && reg_addr == 8'h22 ##1
    reg_read && reg_addr == 8'h22 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control readback differs from write");
  AST_TIMING_RSVD: assert property (reg_read && reg_addr == 8'h23
    |=> reg_rdata[7:6] == 2'b00) else $error("timing reserved bits set");
  AST_STATUS_RSVD: assert property (reg_read && reg_addr == 8'h89
    |=> !reg_rdata[6]) else $error("status reserved bit set");
  AST_OUT_VALID: assert property (sample_in_valid && bridge_output_enable
    |=> sample_out_valid) else $error("sample not passed on");
  AST_NO_VALID: assert property (!sample_in_valid |=> !sample_out_valid)
    else $error("output valid without input");
  AST_LOCK_ZERO: assert property ($past(!bridge_output_enable) &&
    !bridge_output_enable |-> sample_out == 16'sh0000)
    else $error("audio present while locked out");
  AST_UV_RELEASE: assert property (power_stage_supply != 5'h00
    |=> bridge_output_enable) else $error("lockout held on nonzero code");
  AST_UV_WAIT: assert property ($fell(bridge_output_enable)
    |-> zero_run >= UV_HOLD_CYCLES - 2) else $error("lockout too early");
  AST_UV_SET: assert property (zero_run == UV_HOLD_CYCLES + 2
    |-> !bridge_output_enable) else $error("lockout too late");
  cover property (sample_out_valid);
  cover property ($fell(bridge_output_enable));
  cover property (reg_read && reg_addr == 8'h89);
endmodule // supply_comp_checker
`default_nettype wire

//--- test_supply_compensated_gain_control.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// bench top
module test_supply_compensated_gain_control;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic reg_write = 1'b0, reg_read = 1'b0, sample_in_valid = 1'b0;
  logic signed [15:0] sample_in = 16'sh0000;
  logic [4:0] level = 5'h08; // supply level the converter reports
  wire [7:0] reg_rdata;
  wire signed [15:0] sample_out;
  wire [4:0] code;
  wire sample_out_valid, bridge_output_enable, irq;
  int num_errors = 0, total_checks = 0;
  always #10 clock = ~clock;
  supply_sense_model supply_sense_model_inst (.clock(clock), .level(level),
    .code(code));
  // short counts keep the run small: 8-cycle base period, 50-cycle hold
  supply_compensated_gain_control #(.BASE_PERIOD_CYCLES(8),
    .UV_HOLD_CYCLES(50)) supply_compensated_gain_control_inst (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .power_stage_supply(code),
    .sample_in(sample_in), .sample_in_valid(sample_in_valid),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .bridge_output_enable(bridge_output_enable), .irq(irq));
  // ====================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (reg_write) @(posedge clock); // let the last strobe drop first
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    check({8'h00, reg_rdata & m}, {8'h00, e});
  endtask
  task automatic send(input logic [15:0] s);
    if (sample_in_valid) @(posedge clock); // one edge with valid low
    sample_in <= s;
    sample_in_valid <= 1'b1;
    @(posedge clock);
    sample_in_valid <= 1'b0;
  endtask
  // ====================
  // scenarios
  task automatic test_regs();
    rc(8'h22, 8'hFF, 8'h08);
    rc(8'h23, 8'hFF, 8'h04);
    rc(8'h89, 8'hFF, 8'h00);
    rc(8'h00, 8'hFF, 8'h00);
    wr(8'h23, 8'hFF);
    rc(8'h23, 8'hFF, 8'h3F);
    wr(8'h22, 8'hC8);
    rc(8'h22, 8'hFF, 8'hC8);
    wr(8'h89, 8'hFF);
    rc(8'h89, 8'hFF, 8'h00);
    wr(8'h23, 8'h00);
    $display("register test done");
  endtask
  task automatic test_corr();
    logic [7:0] ctl [6] = '{8'hC9, 8'h89, 8'h49, 8'h49, 8'hC0, 8'hDF};
    logic [4:0] lvl [6] = '{5'h0D, 5'h05, 5'h05, 5'h0D, 5'h1F, 5'h01};
    logic [7:0] res [6] = '{8'h3C, 8'h00, 8'h04, 8'h00, 8'h21, 8'h1E};
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h22, ctl[i]);
      level <= lvl[i];
      cyc(24);
      rc(8'h89, 8'h3F, res[i]);
    end
    $display("correction test done");
  endtask
  task automatic test_irq();
    wr(8'h91, 8'h04);
    cyc(1);
    check({15'h0000, irq}, 16'h0001);
    wr(8'h91, 8'h00);
    cyc(1);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h23, 8'h3F);
    wr(8'h90, 8'h07);
    wr(8'h91, 8'h04);
    cyc(1);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h23, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic test_audio();
    level <= 5'h08;
    wr(8'h22, 8'hC8);
    cyc(24);
    send(16'h1000);
    send(16'hF000);
    check(sample_out, 16'h1000);
    cyc(1);
    check(sample_out, 16'hF000);
    check({15'h0000, sample_out_valid}, 16'h0001);
    $display("audio test done");
  endtask
  task automatic test_jump();
    wr(8'h22, 8'h28);
    cyc(24);
    level <= 5'h14;
    cyc(12);
    rc(8'h89, 8'hA0, 8'hA0);
    cyc(400);
    rc(8'h89, 8'hFF, 8'h00);
    level <= 5'h18;
    cyc(24);
    rc(8'h89, 8'h80, 8'h00);
    $display("jump test done");
  endtask
  task automatic test_undervolt();
    level <= 5'h00;
    cyc(30);
    check({15'h0000, bridge_output_enable}, 16'h0001);
    cyc(40);
    check({15'h0000, bridge_output_enable}, 16'h0000);
    send(16'h1000);
    cyc(2);
    check(sample_out, 16'h0000);
    level <= 5'h08;
    cyc(3);
    check({15'h0000, bridge_output_enable}, 16'h0001);
    $display("undervolt test done");
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ====================
  // main sequence and watchdog
  initial
  begin
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    test_regs();
    test_corr();
    test_irq();
    test_audio();
    test_jump();
    test_undervolt();
    end_of_test();
  end
  initial
  begin
    cyc(5000);
    num_errors++;
    end_of_test();
  end
endmodule // test_supply_compensated_gain_control
bind supply_compensated_gain_control supply_comp_checker
  #(.UV_HOLD_CYCLES(UV_HOLD_CYCLES)) checker_inst (.clock(clock),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .power_stage_supply(power_stage_supply),
  .sample_in_valid(sample_in_valid), .sample_out(sample_out),
  .sample_out_valid(sample_out_valid),
  .bridge_output_enable(bridge_output_enable));
`default_nettype wire
